// ===== src/fsbra_defs.svh
// Widths, bit positions and cycle counts of the request phase link
`ifndef FSBRA_DEFS_SVH
`define FSBRA_DEFS_SVH
// Address lines carry A[35:3]
`define FSBRA_AW 33
`define FSBRA_RW 5
// Each address strobe qualifies 19 lines
`define FSBRA_GW 19
// Index of A[16] and A[20] within the A[35:3] vector
`define FSBRA_LO_TOP 13
`define FSBRA_A20_IDX 17
`define FSBRA_BPM_W 4
// Edges from the address strobe to the whole request being latched
`define FSBRA_CAP_DLY 2'h2
// Bus clocks the priority agent waits after raising its request
`define FSBRA_GUARD 3'h4
`endif

// ===== src/fsbra_pkg.sv
// Types shared by both ends of the request phase link
`include "fsbra_defs.svh"
package fsbra_pkg;
   typedef logic [`FSBRA_AW-1:0] fsbra_addr_t;
   typedef logic [`FSBRA_RW-1:0] fsbra_req_t;
   typedef logic [`FSBRA_GW-1:0] fsbra_grp_t;
   // Processor end request phase
   typedef enum logic [1:0] {
      D_IDLE = 2'h0,
      D_SUB1 = 2'h1,
      D_SUB2 = 2'h3,
      D_GAP = 2'h2
   } fsbra_dtx_t;
   // Hub end request phase
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_ARB = 3'h1,
      H_SUB1 = 3'h3,
      H_SUB2 = 3'h2,
      H_REL = 3'h6
   } fsbra_htx_t;
endpackage : fsbra_pkg

// ===== src/fsbra_if.sv
// Pins between the processor end and the hub end
`timescale 1ns/1ps
interface fsbra_if;
   import fsbra_pkg::*;
   logic bclk;
   fsbra_addr_t dev_addr, hub_addr, addr;
   fsbra_req_t dev_req, hub_req, req;
   logic [1:0] dev_strb, hub_strb, strb;
   logic dev_ads, hub_ads, ads, dev_oe, hub_oe;
   logic dev_bnr, dev_bnr_oe, hub_bnr, hub_bnr_oe, bnr;
   logic br, priority_agent_request, bit20_mask_input;
   logic [`FSBRA_BPM_W-1:0] dev_bpm, dev_bpm_oe, bpm;
   // ==========================================
   // Wire resolution, undriven lines read low
   assign addr = ({`FSBRA_AW{dev_oe}} & dev_addr) | ({`FSBRA_AW{hub_oe}} & hub_addr);
   assign req = ({`FSBRA_RW{dev_oe}} & dev_req) | ({`FSBRA_RW{hub_oe}} & hub_req);
   assign strb = ({2{dev_oe}} & dev_strb) | ({2{hub_oe}} & hub_strb);
   assign ads = (dev_oe & dev_ads) | (hub_oe & hub_ads);
   assign bnr = (dev_bnr_oe & dev_bnr) | (hub_bnr_oe & hub_bnr);
   assign bpm = dev_bpm_oe & dev_bpm;
   modport dev (
      input bclk, addr, req, strb, ads, bnr, priority_agent_request, bit20_mask_input, bpm,
      output dev_addr, dev_req, dev_strb, dev_ads, dev_oe, dev_bnr, dev_bnr_oe, br,
      output dev_bpm, dev_bpm_oe
   );
   modport hub (
      input addr, req, strb, ads, bnr, br, bpm,
      output bclk, hub_addr, hub_req, hub_strb, hub_ads, hub_oe, hub_bnr, hub_bnr_oe,
      output priority_agent_request, bit20_mask_input
   );
endinterface : fsbra_if

// ===== src/fsbra_strobe_rx.sv
// Latch of one address strobe group on both strobe edges
`timescale 1ns/1ps
module fsbra_strobe_rx #(
   parameter int W = `FSBRA_GW
) (
   input wire logic strobe_i,
   input wire logic [W-1:0] lines_i,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   // Rising edge holds subphase one, falling edge subphase two
   always_ff @(posedge strobe_i) begin
      rise_o <= lines_i;
   end
   always_ff @(negedge strobe_i) begin
      fall_o <= lines_i;
   end
endmodule : fsbra_strobe_rx

// ===== src/fsbra_cpu_end.sv
// Processor end of the request phase and arbitration link
`timescale 1ns/1ps
// Operation
// - Subphase one drives the physical address
// - Subphase two drives attributes on address lines
// - Sample address lines as straps during reset
// - Latch lines on both strobe edges
// - Strobe 0: type, A16-3; strobe 1: A35-17
// - Mask forces address bit 20 low
// - Mask only asserted in real mode
// - Mask asynchronous, valid by target ready
// - Address strobe marks a new transaction
// - Address strobe starts decode and checks
// - All timing on bus clock rising edge; strobes here toggle on the falling edge
// - Agent that cannot accept asserts block
// - Owner issues nothing while blocked
// - Drive breakpoint monitor pins, two bidirectional
// - Priority request stops new unlocked requests
// - Priority agent holds request until done
// - Symmetric agent raises its bus request
module fsbra_cpu_end (
   fsbra_if.dev bus,
   input wire logic RESET_I,
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire fsbra_pkg::fsbra_addr_t REQ_ADDR_I,
   input wire fsbra_pkg::fsbra_addr_t REQ_ATTR_I,
   input wire fsbra_pkg::fsbra_req_t REQ_TYPE1_I,
   input wire fsbra_pkg::fsbra_req_t REQ_TYPE2_I,
   input wire logic REQ_LOCK_I,
   output fsbra_pkg::fsbra_addr_t LOOKUP_ADDR_O,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   output fsbra_pkg::fsbra_addr_t RX_ADDR_O,
   output fsbra_pkg::fsbra_addr_t RX_ATTR_O,
   output fsbra_pkg::fsbra_req_t RX_TYPE1_O,
   output fsbra_pkg::fsbra_req_t RX_TYPE2_O,
   output logic PROTO_ERR_O,
   output fsbra_pkg::fsbra_addr_t STRAP_O,
   input wire logic [`FSBRA_BPM_W-1:0] BPM_STATUS_I,
   output logic [1:0] BPM_IN_O
);
   import fsbra_pkg::*;

   // ==========================================
   // State
   fsbra_dtx_t st_reg, st_next;
   fsbra_addr_t line_reg, line_next, attr_reg, attr_next, look_reg, look_next;
   fsbra_req_t rq_reg, rq_next, t2_reg, t2_next;
   logic oe_reg, oe_next, ads_reg, ads_next;
   logic ready_reg, ready_next, br_reg, br_next, lock_reg, lock_next;
   logic [1:0] strb_reg;
   logic [1:0] cnt_reg, cnt_next;
   logic rxv_reg, rxv_next, bnr_reg, bnr_next, perr_reg, perr_next;
   fsbra_addr_t rxa_reg, rxa_next, rxt_reg, rxt_next, strap_reg, strap_next;
   fsbra_req_t rx1_reg, rx1_next, rx2_reg, rx2_next;
   logic [`FSBRA_BPM_W-1:0] bpm_reg, bpm_next, bpmoe_reg, bpmoe_next;
   logic a20_s1_reg, a20_s2_reg;
   logic [1:0] bpm_s1_reg, bpm_s2_reg;
   logic take, ads_seen;
   fsbra_addr_t masked;
   fsbra_grp_t g0_rise, g0_fall, g1_rise, g1_fall;

   // ==========================================
   // Strobe groups
   fsbra_strobe_rx #(.W(`FSBRA_GW)) u_grp0 (
      .strobe_i(bus.strb[0]),
      .lines_i({bus.req, bus.addr[`FSBRA_LO_TOP:0]}),
      .rise_o(g0_rise),
      .fall_o(g0_fall)
   );
   fsbra_strobe_rx #(.W(`FSBRA_GW)) u_grp1 (
      .strobe_i(bus.strb[1]),
      .lines_i(bus.addr[`FSBRA_AW-1:`FSBRA_LO_TOP+1]),
      .rise_o(g1_rise),
      .fall_o(g1_fall)
   );

   // ==========================================
   // Next state
   always_comb begin
      st_next = st_reg;
      line_next = line_reg;
      attr_next = attr_reg;
      look_next = look_reg;
      rq_next = rq_reg;
      t2_next = t2_reg;
      oe_next = oe_reg;
      ads_next = 1'b0;
      lock_next = lock_reg;
      cnt_next = cnt_reg;
      rxv_next = rxv_reg;
      perr_next = perr_reg;
      rxa_next = rxa_reg;
      rxt_next = rxt_reg;
      rx1_next = rx1_reg;
      rx2_next = rx2_reg;
      take = REQ_VALID_I && ready_reg;
      // Mask sampled through the synchroniser only
      masked = REQ_ADDR_I;
      masked[`FSBRA_A20_IDX] = REQ_ADDR_I[`FSBRA_A20_IDX] & ~a20_s2_reg;
      unique case (st_reg)
         D_IDLE: begin
            if (take) begin
               st_next = D_SUB1;
               oe_next = 1'b1;
               ads_next = 1'b1;
               line_next = masked;
               rq_next = REQ_TYPE1_I;
               look_next = masked;
               attr_next = REQ_ATTR_I;
               t2_next = REQ_TYPE2_I;
               lock_next = REQ_LOCK_I;
            end else if (!REQ_LOCK_I) begin
               lock_next = 1'b0;
            end
         end
         D_SUB1: begin
            st_next = D_SUB2;
            line_next = attr_reg;
            rq_next = t2_reg;
         end
         D_SUB2: begin
            st_next = D_GAP;
            oe_next = 1'b0;
         end
         D_GAP: begin
            st_next = D_IDLE;
         end
      endcase
      // Issue only as owner: not blocked, no priority request unless locked
      ready_next = (st_next == D_IDLE) && br_reg && !bus.bnr
         && (!bus.priority_agent_request || (lock_next && REQ_LOCK_I));
      br_next = REQ_VALID_I || (st_next != D_IDLE);
      // ==========================================
      // Receive from the hub, own strobe ignored
      ads_seen = bus.ads && !oe_reg;
      if (rxv_reg && RX_READY_I) begin
         rxv_next = 1'b0;
      end
      if (ads_seen) begin
         if (cnt_reg != 2'h0 || rxv_reg) begin
            perr_next = 1'b1;
         end
         cnt_next = `FSBRA_CAP_DLY;
      end else if (cnt_reg != 2'h0) begin
         cnt_next = cnt_reg - 2'h1;
         // Type one latches with the address; attributes and type two latch on the falling strobe edge, so capture waits
         if (cnt_reg == 2'h1) begin
            rxv_next = 1'b1;
            rxa_next = {g1_rise, g0_rise[`FSBRA_LO_TOP:0]};
            rxt_next = {g1_fall, g0_fall[`FSBRA_LO_TOP:0]};
            rx1_next = g0_rise[`FSBRA_GW-1:`FSBRA_LO_TOP+1];
            rx2_next = g0_fall[`FSBRA_GW-1:`FSBRA_LO_TOP+1];
         end
      end
      // Block while the single receive slot is in use
      bnr_next = rxv_next || (cnt_next != 2'h0);
      strap_next = RESET_I ? bus.addr : strap_reg;
      bpm_next = BPM_STATUS_I;
      bpmoe_next = {`FSBRA_BPM_W{1'b1}};
   end

   // ==========================================
   // Registers on the bus clock
   always_ff @(posedge bus.bclk) begin
      strap_reg <= strap_next;
      a20_s1_reg <= bus.bit20_mask_input;
      a20_s2_reg <= a20_s1_reg;
      bpm_s1_reg <= {bus.bpm[3], bus.bpm[0]};
      bpm_s2_reg <= bpm_s1_reg;
      line_reg <= line_next;
      attr_reg <= attr_next;
      rq_reg <= rq_next;
      t2_reg <= t2_next;
      rxa_reg <= rxa_next;
      rxt_reg <= rxt_next;
      rx1_reg <= rx1_next;
      rx2_reg <= rx2_next;
      bpm_reg <= bpm_next;
      if (RESET_I) begin
         st_reg <= D_IDLE;
         oe_reg <= 1'b0;
         ads_reg <= 1'b0;
         look_reg <= '0;
         ready_reg <= 1'b0;
         br_reg <= 1'b0;
         lock_reg <= 1'b0;
         cnt_reg <= 2'h0;
         rxv_reg <= 1'b0;
         bnr_reg <= 1'b0;
         perr_reg <= 1'b0;
         bpmoe_reg <= '0;
      end else begin
         st_reg <= st_next;
         oe_reg <= oe_next;
         ads_reg <= ads_next;
         look_reg <= look_next;
         ready_reg <= ready_next;
         br_reg <= br_next;
         lock_reg <= lock_next;
         cnt_reg <= cnt_next;
         rxv_reg <= rxv_next;
         bnr_reg <= bnr_next;
         perr_reg <= perr_next;
         bpmoe_reg <= bpmoe_next;
      end
   end

   // Strobes toggle mid-cycle so both edges sit in stable data
   always_ff @(negedge bus.bclk) begin
      strb_reg <= {2{st_reg == D_SUB1}};
   end

   // ==========================================
   // Outputs
   assign bus.dev_addr = line_reg;
   assign bus.dev_req = rq_reg;
   assign bus.dev_strb = strb_reg;
   assign bus.dev_ads = ads_reg;
   assign bus.dev_oe = oe_reg;
   assign bus.dev_bnr = bnr_reg;
   assign bus.dev_bnr_oe = bnr_reg;
   assign bus.br = br_reg;
   assign bus.dev_bpm = bpm_reg;
   assign bus.dev_bpm_oe = bpmoe_reg;
   assign REQ_READY_O = ready_reg;
   assign LOOKUP_ADDR_O = look_reg;
   assign RX_VALID_O = rxv_reg;
   assign RX_ADDR_O = rxa_reg;
   assign RX_ATTR_O = rxt_reg;
   assign RX_TYPE1_O = rx1_reg;
   assign RX_TYPE2_O = rx2_reg;
   assign PROTO_ERR_O = perr_reg;
   assign STRAP_O = strap_reg;
   assign BPM_IN_O = bpm_s2_reg;
endmodule : fsbra_cpu_end

// ===== src/fsbra_hub_end.sv
// Hub end: priority agent, bus clock source and strap driver
`timescale 1ns/1ps
module fsbra_hub_end (
   fsbra_if.hub bus,
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire fsbra_pkg::fsbra_addr_t STRAP_I,
   input wire logic A20_MASK_I,
   input wire logic REAL_MODE_I,
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire fsbra_pkg::fsbra_addr_t REQ_ADDR_I,
   input wire fsbra_pkg::fsbra_addr_t REQ_ATTR_I,
   input wire fsbra_pkg::fsbra_req_t REQ_TYPE1_I,
   input wire fsbra_pkg::fsbra_req_t REQ_TYPE2_I,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   output fsbra_pkg::fsbra_addr_t RX_ADDR_O,
   output fsbra_pkg::fsbra_addr_t RX_ATTR_O,
   output fsbra_pkg::fsbra_req_t RX_TYPE1_O,
   output fsbra_pkg::fsbra_req_t RX_TYPE2_O,
   output logic DEV_BR_O,
   output logic [`FSBRA_BPM_W-1:0] BPM_O
);
   import fsbra_pkg::*;

   // ==========================================
   // State
   // Free running so the processor sees edges during its reset
   logic bclk_reg = 1'b0;
   logic bclk_next;
   fsbra_htx_t st_reg, st_next;
   fsbra_addr_t line_reg, line_next, attr_reg, attr_next;
   fsbra_req_t rq_reg, rq_next, t2_reg, t2_next;
   logic oe_reg, oe_next, ads_reg, ads_next, strb_reg, strb_next;
   logic ready_reg, ready_next, priority_agent_request_reg, priority_agent_request_next, a20_reg, a20_next;
   logic [2:0] guard_reg, guard_next;
   logic [1:0] cnt_reg, cnt_next;
   logic rxv_reg, rxv_next, bnr_reg, bnr_next, br_reg;
   fsbra_addr_t rxa_reg, rxa_next, rxt_reg, rxt_next;
   fsbra_req_t rx1_reg, rx1_next, rx2_reg, rx2_next;
   logic [`FSBRA_BPM_W-1:0] bpm_reg;
   fsbra_grp_t g0_rise, g0_fall, g1_rise, g1_fall;

   fsbra_strobe_rx #(.W(`FSBRA_GW)) u_grp0 (
      .strobe_i(bus.strb[0]),
      .lines_i({bus.req, bus.addr[`FSBRA_LO_TOP:0]}),
      .rise_o(g0_rise),
      .fall_o(g0_fall)
   );
   fsbra_strobe_rx #(.W(`FSBRA_GW)) u_grp1 (
      .strobe_i(bus.strb[1]),
      .lines_i(bus.addr[`FSBRA_AW-1:`FSBRA_LO_TOP+1]),
      .rise_o(g1_rise),
      .fall_o(g1_fall)
   );

   // ==========================================
   // Next state; bus moves on the falling half so the far end samples settled pins
   always_comb begin
      bclk_next = ~bclk_reg;
      st_next = st_reg;
      line_next = line_reg;
      attr_next = attr_reg;
      rq_next = rq_reg;
      t2_next = t2_reg;
      oe_next = (st_reg == H_IDLE) ? 1'b0 : oe_reg;
      ads_next = ads_reg;
      strb_next = strb_reg;
      priority_agent_request_next = priority_agent_request_reg;
      guard_next = guard_reg;
      cnt_next = cnt_reg;
      rxv_next = rxv_reg;
      rxa_next = rxa_reg;
      rxt_next = rxt_reg;
      rx1_next = rx1_reg;
      rx2_next = rx2_reg;
      a20_next = A20_MASK_I && REAL_MODE_I;
      if (rxv_reg && RX_READY_I) begin
         rxv_next = 1'b0;
      end
      if (bclk_reg) begin
         unique case (st_reg)
            H_IDLE: begin
               if (REQ_VALID_I && ready_reg) begin
                  st_next = H_ARB;
                  priority_agent_request_next = 1'b1;
                  guard_next = 3'h0;
                  line_next = REQ_ADDR_I;
                  rq_next = REQ_TYPE1_I;
                  attr_next = REQ_ATTR_I;
                  t2_next = REQ_TYPE2_I;
               end
            end
            H_ARB: begin
               // Let a request the processor already began finish
               if (guard_reg != `FSBRA_GUARD) begin
                  guard_next = guard_reg + 3'h1;
               end else if (!bus.bnr && !bus.ads) begin
                  st_next = H_SUB1;
                  oe_next = 1'b1;
                  ads_next = 1'b1;
               end
            end
            H_SUB1: begin
               st_next = H_SUB2;
               ads_next = 1'b0;
               line_next = attr_reg;
               rq_next = t2_reg;
            end
            H_SUB2: begin
               st_next = H_REL;
               oe_next = 1'b0;
               priority_agent_request_next = 1'b0;
            end
            H_REL: begin
               st_next = H_IDLE;
            end
            default: begin
               st_next = H_IDLE;
            end
         endcase
         if (bus.ads && !oe_reg) begin
            cnt_next = `FSBRA_CAP_DLY;
         end else if (cnt_reg != 2'h0) begin
            cnt_next = cnt_reg - 2'h1;
            if (cnt_reg == 2'h1) begin
               rxv_next = 1'b1;
               rxa_next = {g1_rise, g0_rise[`FSBRA_LO_TOP:0]};
               rxt_next = {g1_fall, g0_fall[`FSBRA_LO_TOP:0]};
               rx1_next = g0_rise[`FSBRA_GW-1:`FSBRA_LO_TOP+1];
               rx2_next = g0_fall[`FSBRA_GW-1:`FSBRA_LO_TOP+1];
            end
         end
      end else begin
         if (st_reg == H_SUB1) begin
            strb_next = 1'b1;
         end else if (st_reg == H_SUB2) begin
            strb_next = 1'b0;
         end
      end
      ready_next = (st_next == H_IDLE) && !bclk_reg;
      bnr_next = rxv_next || (cnt_next != 2'h0);
   end

   // ==========================================
   // Registers
   always_ff @(posedge CLK_I) begin
      bclk_reg <= bclk_next;
      attr_reg <= attr_next;
      t2_reg <= t2_next;
      rxa_reg <= rxa_next;
      rxt_reg <= rxt_next;
      rx1_reg <= rx1_next;
      rx2_reg <= rx2_next;
      bpm_reg <= bus.bpm;
      br_reg <= bus.br;
      if (RESET_I) begin
         // Straps stay on the address lines through reset
         line_reg <= STRAP_I;
         oe_reg <= 1'b1;
         rq_reg <= '0;
         st_reg <= H_IDLE;
         ads_reg <= 1'b0;
         strb_reg <= 1'b0;
         ready_reg <= 1'b0;
         priority_agent_request_reg <= 1'b0;
         a20_reg <= 1'b0;
         guard_reg <= 3'h0;
         cnt_reg <= 2'h0;
         rxv_reg <= 1'b0;
         bnr_reg <= 1'b0;
      end else begin
         line_reg <= line_next;
         oe_reg <= oe_next;
         rq_reg <= rq_next;
         st_reg <= st_next;
         ads_reg <= ads_next;
         strb_reg <= strb_next;
         ready_reg <= ready_next;
         priority_agent_request_reg <= priority_agent_request_next;
         a20_reg <= a20_next;
         guard_reg <= guard_next;
         cnt_reg <= cnt_next;
         rxv_reg <= rxv_next;
         bnr_reg <= bnr_next;
      end
   end

   assign bus.bclk = bclk_reg;
   assign bus.hub_addr = line_reg;
   assign bus.hub_req = rq_reg;
   assign bus.hub_strb = {2{strb_reg}};
   assign bus.hub_ads = ads_reg;
   assign bus.hub_oe = oe_reg;
   assign bus.hub_bnr = bnr_reg;
   assign bus.hub_bnr_oe = bnr_reg;
   assign bus.priority_agent_request = priority_agent_request_reg;
   assign bus.bit20_mask_input = a20_reg;
   assign REQ_READY_O = ready_reg;
   assign RX_VALID_O = rxv_reg;
   assign RX_ADDR_O = rxa_reg;
   assign RX_ATTR_O = rxt_reg;
   assign RX_TYPE1_O = rx1_reg;
   assign RX_TYPE2_O = rx2_reg;
   assign DEV_BR_O = br_reg;
   assign BPM_O = bpm_reg;
endmodule : fsbra_hub_end

// ===== verification/fsbra_asserts.sv
// Checker of the request phase link, watching the interface pins
`timescale 1ns/1ps
`include "fsbra_defs.svh"
module fsbra_asserts (
   input wire logic bclk,
   input wire logic RESET_I,
   input wire logic dev_ads,
   input wire logic dev_oe,
   input wire logic hub_ads,
   input wire logic hub_oe,
   input wire logic dev_bnr,
   input wire logic dev_bnr_oe,
   input wire logic bnr,
   input wire logic br,
   input wire logic priority_agent_request,
   input wire logic bit20_mask_input,
   input wire fsbra_pkg::fsbra_addr_t dev_addr,
   input wire logic [`FSBRA_BPM_W-1:0] dev_bpm_oe
);
   import fsbra_pkg::*;
   default clocking cb @(posedge bclk);
   endclocking
   default disable iff (RESET_I);
   // ==========================================
   // Processor request phase
   sequence s_dev_sub2;
      !dev_ads && dev_oe;
   endsequence
   sequence s_dev_off;
      !dev_oe;
   endsequence
   property p_dev_phase;
      dev_ads && dev_oe |=> s_dev_sub2 ##1 s_dev_off;
   endproperty
   a_dev_phase: assert property (p_dev_phase) else $error("processor phase length wrong");
   property p_dev_gap;
      dev_ads |=> !dev_ads [*3];
   endproperty
   a_dev_gap: assert property (p_dev_gap) else $error("processor requests too close");
   property p_bnr_stall;
      $rose(dev_ads) |-> !($past(bnr) && $past(bnr, 2));
   endproperty
   a_bnr_stall: assert property (p_bnr_stall) else $error("request issued while stalled");
   property p_priority_agent_request_stop;
      $rose(dev_ads) |-> !($past(priority_agent_request) && $past(priority_agent_request, 2));
   endproperty
   a_priority_agent_request_stop: assert property (p_priority_agent_request_stop) else $error("request issued under priority");
   property p_br_first;
      $rose(dev_ads) |-> $past(br, 2);
   endproperty
   a_br_first: assert property (p_br_first) else $error("request without bus request");
   property p_mask;
      $rose(dev_ads) && $past(bit20_mask_input, 2) && $past(bit20_mask_input, 3) && $past(bit20_mask_input, 4)
         |-> !dev_addr[`FSBRA_A20_IDX];
   endproperty
   a_mask: assert property (p_mask) else $error("bit 20 not masked");
   // ==========================================
   // Hub side and shared lines
   property p_priority_agent_request_hold;
      hub_ads && hub_oe |-> priority_agent_request;
   endproperty
   a_priority_agent_request_hold: assert property (p_priority_agent_request_hold) else $error("hub request without priority");
   property p_priority_agent_request_guard;
      $rose(priority_agent_request) |-> !hub_oe [*4];
   endproperty
   a_priority_agent_request_guard: assert property (p_priority_agent_request_guard) else $error("hub drove inside guard");
   property p_rx_block;
      hub_ads && hub_oe |-> ##[1:2] (dev_bnr && dev_bnr_oe);
   endproperty
   a_rx_block: assert property (p_rx_block) else $error("no block after receive");
   property p_one_drv;
      !(dev_oe && hub_oe);
   endproperty
   a_one_drv: assert property (p_one_drv) else $error("both ends drive the lines");
   property p_bpm_oe;
      !$past(RESET_I) |-> dev_bpm_oe == {`FSBRA_BPM_W{1'b1}};
   endproperty
   a_bpm_oe: assert property (p_bpm_oe) else $error("monitor pins not driven");
endmodule : fsbra_asserts

// ===== verification/tb_top.sv
// Self-checking bench of both link ends joined through the interface
`timescale 1ns/1ps
`include "fsbra_defs.svh"
module tb_top;
   import fsbra_pkg::*;
   // Arbitrary strap pattern
   localparam fsbra_addr_t STRAP = 33'h1_2345_6789;
   localparam fsbra_addr_t FULL = 33'h1_ffff_ffff;
   localparam fsbra_addr_t M20 = 33'h1 << `FSBRA_A20_IDX;
   localparam fsbra_addr_t TX1 = 33'h0_1234_5678;
   localparam fsbra_addr_t TX2 = 33'h1_8765_4321;
   logic clk = 1'b0;
   logic rst_cpu = 1'b1;
   logic rst_hub = 1'b1;
   logic a20_mask = 1'b0;
   logic real_mode = 1'b0;
   logic [3:0] bpm_status = 4'h0;
   logic cv = 1'b0, cr = 1'b0, hv = 1'b0, hr = 1'b0;
   fsbra_addr_t ra = '0, rat = '0;
   fsbra_req_t rt1 = '0, rt2 = '0;
   logic c_ready, c_rx_v, c_err, h_ready, h_rx_v, h_br;
   fsbra_addr_t c_look, c_rx_a, c_rx_at, c_strap, h_rx_a, h_rx_at;
   fsbra_req_t c_rx_t1, c_rx_t2, h_rx_t1, h_rx_t2;
   logic [1:0] c_bpm_in;
   logic [3:0] h_bpm;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   wire bclk = fsbra_if_i.bclk;
   always #20 clk = ~clk;
   // ==========================================
   // Both ends across one interface
   fsbra_if fsbra_if_i ();
   fsbra_cpu_end fsbra_cpu_end_i (.bus(fsbra_if_i), .RESET_I(rst_cpu), .REQ_VALID_I(cv),
      .REQ_READY_O(c_ready), .REQ_ADDR_I(ra), .REQ_ATTR_I(rat), .REQ_TYPE1_I(rt1),
      .REQ_TYPE2_I(rt2), .REQ_LOCK_I(1'b0), .LOOKUP_ADDR_O(c_look), .RX_VALID_O(c_rx_v),
      .RX_READY_I(cr), .RX_ADDR_O(c_rx_a), .RX_ATTR_O(c_rx_at), .RX_TYPE1_O(c_rx_t1),
      .RX_TYPE2_O(c_rx_t2), .PROTO_ERR_O(c_err), .STRAP_O(c_strap),
      .BPM_STATUS_I(bpm_status), .BPM_IN_O(c_bpm_in));
   fsbra_hub_end fsbra_hub_end_i (.bus(fsbra_if_i), .CLK_I(clk), .RESET_I(rst_hub),
      .STRAP_I(STRAP), .A20_MASK_I(a20_mask), .REAL_MODE_I(real_mode), .REQ_VALID_I(hv),
      .REQ_READY_O(h_ready), .REQ_ADDR_I(ra), .REQ_ATTR_I(rat), .REQ_TYPE1_I(rt1),
      .REQ_TYPE2_I(rt2), .RX_VALID_O(h_rx_v), .RX_READY_I(hr), .RX_ADDR_O(h_rx_a),
      .RX_ATTR_O(h_rx_at), .RX_TYPE1_O(h_rx_t1), .RX_TYPE2_O(h_rx_t2), .DEV_BR_O(h_br),
      .BPM_O(h_bpm));
   // Hub reset covers the checker: hub holds the lines with straps until then
   fsbra_asserts chk_i (.bclk(fsbra_if_i.bclk), .RESET_I(rst_hub), .dev_ads(fsbra_if_i.dev_ads),
      .dev_oe(fsbra_if_i.dev_oe), .hub_ads(fsbra_if_i.hub_ads), .hub_oe(fsbra_if_i.hub_oe),
      .dev_bnr(fsbra_if_i.dev_bnr), .dev_bnr_oe(fsbra_if_i.dev_bnr_oe), .bnr(fsbra_if_i.bnr),
      .br(fsbra_if_i.br), .priority_agent_request(fsbra_if_i.priority_agent_request), .bit20_mask_input(fsbra_if_i.bit20_mask_input),
      .dev_addr(fsbra_if_i.dev_addr), .dev_bpm_oe(fsbra_if_i.dev_bpm_oe));
   // ==========================================
   // Shared tasks
   task automatic conclude();
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input bit hub);
      if (hub) @(posedge clk);
      else @(posedge bclk);
      #2;
   endtask : tick
   task automatic send(input bit hub, input fsbra_addr_t a, input fsbra_addr_t at,
         input fsbra_req_t t1, input fsbra_req_t t2);
      int k;
      tick(hub);
      ra = a;
      rat = at;
      rt1 = t1;
      rt2 = t2;
      if (hub) hv = 1'b1;
      else cv = 1'b1;
      for (k = 0; k < 400 && (hub ? h_ready : c_ready) !== 1'b1; k++) tick(hub);
      if (!hub) check(h_br, 1'b1);
      tick(hub);
      hv = 1'b0;
      cv = 1'b0;
   endtask : send
   task automatic rx_check(input bit hub, input fsbra_addr_t a, input fsbra_addr_t at,
         input fsbra_req_t t1, input fsbra_req_t t2);
      int k;
      for (k = 0; k < 400 && (hub ? h_rx_v : c_rx_v) !== 1'b1; k++) tick(hub);
      check(hub ? h_rx_v : c_rx_v, 1'b1);
      check(hub ? h_rx_a : c_rx_a, a);
      check(hub ? h_rx_at : c_rx_at, at);
      check(hub ? h_rx_t1 : c_rx_t1, t1);
      check(hub ? h_rx_t2 : c_rx_t2, t2);
      if (hub) hr = 1'b1;
      else cr = 1'b1;
      for (k = 0; k < 400 && (hub ? h_rx_v : c_rx_v) !== 1'b0; k++) tick(hub);
      hr = 1'b0;
      cr = 1'b0;
   endtask : rx_check
   // ==========================================
   // Scenarios
   task automatic t_traffic();
      fsbra_addr_t pats [3] = '{33'h1_ffff_c000, 33'h0_0000_3fff, 33'h1_5555_5555};
      foreach (pats[i]) begin
         send(1'b0, pats[i], ~pats[i], 5'h15 ^ 5'(i), 5'h0a ^ 5'(i));
         rx_check(1'b1, pats[i], ~pats[i], 5'h15 ^ 5'(i), 5'h0a ^ 5'(i));
         check(c_look, pats[i]);
         send(1'b1, ~pats[i], pats[i], 5'h0a ^ 5'(i), 5'h15 ^ 5'(i));
         rx_check(1'b0, ~pats[i], pats[i], 5'h0a ^ 5'(i), 5'h15 ^ 5'(i));
      end
      $display("test traffic done");
   endtask : t_traffic
   task automatic t_mask();
      tick(1'b1);
      real_mode = 1'b1;
      a20_mask = 1'b1;
      repeat (8) tick(1'b1);
      send(1'b0, FULL, '0, 5'h01, 5'h02);
      rx_check(1'b1, FULL & ~M20, '0, 5'h01, 5'h02);
      check(c_look, FULL & ~M20);
      real_mode = 1'b0;
      repeat (8) tick(1'b1);
      send(1'b0, FULL, '0, 5'h01, 5'h02);
      rx_check(1'b1, FULL, '0, 5'h01, 5'h02);
      check(c_look, FULL);
      a20_mask = 1'b0;
      $display("test mask done");
   endtask : t_mask
   task automatic t_stall();
      int rdy;
      // Processor keeps the first one unacknowledged, so it must block the second
      send(1'b1, TX1, ~TX1, 5'h03, 5'h1c);
      send(1'b1, TX2, ~TX2, 5'h0c, 5'h13);
      ra = 33'h0_0f0f_f0f0;
      cv = 1'b1;
      rdy = 0;
      repeat (20) begin
         tick(1'b0);
         rdy += int'(c_ready === 1'b1);
      end
      cv = 1'b0;
      check(rdy, 0);
      check(c_rx_a, TX1);
      rx_check(1'b0, TX1, ~TX1, 5'h03, 5'h1c);
      rx_check(1'b0, TX2, ~TX2, 5'h0c, 5'h13);
      send(1'b0, 33'h0_0f0f_f0f0, FULL, 5'h07, 5'h18);
      rx_check(1'b1, 33'h0_0f0f_f0f0, FULL, 5'h07, 5'h18);
      $display("test stall done");
   endtask : t_stall
   task automatic t_bpm();
      logic [3:0] vals [2] = '{4'ha, 4'h5};
      foreach (vals[i]) begin
         tick(1'b0);
         bpm_status = vals[i];
         repeat (6) tick(1'b0);
         check(h_bpm, vals[i]);
         check(c_bpm_in, {vals[i][3], vals[i][0]});
      end
      $display("test monitor done");
   endtask : t_bpm
   // ==========================================
   // Main sequence and hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #2;
      rst_cpu = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      rst_hub = 1'b0;
      repeat (4) tick(1'b0);
      check(c_strap, STRAP);
      $display("test strap done");
      t_traffic();
      t_mask();
      t_stall();
      t_bpm();
      check(c_strap, STRAP);
      check(c_err, 1'b0);
      conclude();
   end
endmodule : tb_top
